// File: pkg/cil_pkg.sv
package cil_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;   // soft reset, sleep request/ack, wait-stop
  localparam logic [7:0] OFS_CTRL1 = 8'h04;   // locked: wakeup filter
  localparam logic [7:0] OFS_TIM0 = 8'h08;    // locked bit timing 0
  localparam logic [7:0] OFS_TIM1 = 8'h0c;    // locked bit timing 1
  localparam logic [7:0] OFS_ACCCTL = 8'h10;  // locked acceptance control
  localparam logic [7:0] OFS_ACCCODE = 8'h14; // locked acceptance code, 4 bytes packed
  localparam logic [7:0] OFS_ACCMASK = 8'h18; // locked acceptance mask, 4 bytes packed
  localparam logic [7:0] OFS_RXFLG = 8'h1c;   // receiver flags, write 1 to clear
  localparam logic [7:0] OFS_RXIEN = 8'h20;   // receiver flag enables
  localparam logic [7:0] OFS_TXFLG = 8'h24;   // tx empty flags
  localparam logic [7:0] OFS_TXIEN = 8'h28;   // tx empty enables
  localparam logic [7:0] OFS_ERRCNT = 8'h2c;  // error counters, read only
  localparam logic [7:0] OFS_MODE = 8'h30;    // current mode, read only
  // control 0 fields
  localparam int B_SOFT_RESET_BIT = 0;
  localparam int B_SLEEP_REQUEST = 1;
  localparam int B_SLEEP_ACK = 2;
  localparam int B_WSTOP = 3;
  // control 1 fields
  localparam int B_WFILT = 0;
  // receiver flag fields
  localparam int B_WAKE = 7;
  localparam int B_RWRN = 6;
  localparam int B_TWRN = 5;
  localparam int B_RPAS = 4;
  localparam int B_TPAS = 3;
  localparam int B_BOFF = 2;
  localparam int B_OVR = 1;
  localparam int B_RXF = 0;
  // error counter limits
  localparam logic [8:0] WARN_LIMIT = 9'h060;     // 96
  localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;  // 127
  localparam logic [8:0] BOFF_LIMIT = 9'h0ff;     // 255
  localparam int RECESSIVE_RUN = 11;
  localparam int BOFF_RUNS = 128;
  localparam int GLITCH_CYCLES = 8;
  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    CIL_NORMAL = 2'b00,
    CIL_SLEEP = 2'b01,
    CIL_SOFTRST = 2'b10,
    CIL_PWRDN = 2'b11
  } cil_mode_t;
endpackage

// File: hw/cil_rx_filter.sv
`timescale 1ns/10ps
// low-pass filter on the synchronised receive line
module cil_rx_filter #(
  parameter int LEN = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // line
  input wire logic enable,
  input wire logic rx_in,
  output logic rx_out
);
  logic [$clog2(LEN+1)-1:0] cnt_ff;
  logic out_ff;
  wire differ = (rx_in != out_ff);
  wire full = (cnt_ff == ($clog2(LEN+1))'(LEN));
  // output follows input only after a stable run, when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      out_ff <= 1'b1;
    end else if (ce) begin
      if (!enable || (differ && full)) begin
        out_ff <= rx_in;
        cnt_ff <= '0;
      end else if (differ) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else begin
        cnt_ff <= '0;
      end
    end
  end
  assign rx_out = out_ff;
endmodule // cil_rx_filter

// File: hw/cil_ctrl.sv
`timescale 1ns/10ps
module cil_ctrl
  import cil_pkg::*;
#(
  parameter int FILT_LEN = GLITCH_CYCLES
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host state
  input wire logic host_stop,
  input wire logic host_wait,
  // protocol core status
  input wire logic core_tx_busy,
  input wire logic core_rx_busy,
  input wire logic bit_tick,
  input wire logic [8:0] rx_err_cnt,
  input wire logic [8:0] tx_err_cnt,
  input wire logic overrun_evt,
  input wire logic rx_done_evt,
  input wire logic [2:0] tx_done_evt,
  input wire logic core_tx_bit,
  // bus pins
  input wire logic bus_rx_pin,
  output logic bus_tx_pin,
  // core control
  output logic core_clk_en,
  output logic core_halt,
  output logic copy_allow,
  output logic abort_allow,
  output logic bus_joined,
  output logic boff_recovered,
  output logic [2:0] tx_pending,
  // interrupts
  output logic irq_wakeup,
  output logic irq_error,
  output logic irq_receive,
  output logic irq_transmit
);
  import cil_pkg::*;

  // registers
  logic soft_reset_bit_ff, sleep_request_ff, sleep_ack_ff, wstop_ff;
  logic [31:0] ctrl1_ff, tim0_ff, tim1_ff, accctl_ff, acccode_ff, accmask_ff;
  logic [7:0] rxflg_ff, rxien_ff;
  logic [2:0] txe_ff, txien_ff, pend_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  cil_mode_t mode_ff;
  logic [1:0] rx_sync_ff;
  logic rx_filt, rx_prev_ff;
  logic [3:0] rec_cnt_ff;
  logic [7:0] boff_runs_ff;
  logic joined_ff, boff_rec_ff, tx_pin_ff, clk_en_ff, halt_ff, copy_ff, abort_ff;
  logic irq_w_ff, irq_e_ff, irq_r_ff, irq_t_ff;

  // receive pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_sync_ff <= 2'b11;
    else if (ce) rx_sync_ff <= {rx_sync_ff[0], bus_rx_pin};
  end

  // glitch filter used only while asleep with filter bit set
  cil_rx_filter #(.LEN(FILT_LEN)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .enable(ctrl1_ff[B_WFILT] && mode_ff == CIL_SLEEP),
    .rx_in(rx_sync_ff[1]),
    .rx_out(rx_filt)
  );

  // mode decode
  wire pwrdn = host_stop || (host_wait && wstop_ff);
  cil_mode_t nxt_mode;
  assign nxt_mode = pwrdn ? CIL_PWRDN : sleep_ack_ff ? CIL_SLEEP : soft_reset_bit_ff ? CIL_SOFTRST : CIL_NORMAL;
  wire asleep = (mode_ff == CIL_SLEEP);
  wire bus_act = rx_prev_ff && !rx_filt;  // dominant edge counts as activity

  // apb decode; any access in power-down answers with error
  wire acc = psel && penable && !pready_ff;
  // writes land at the edge that samples pready high, so a stalled master never half-writes
  wire fin = psel && penable && pready_ff;
  wire wr = fin && pwrite && mode_ff != CIL_PWRDN;
  wire rd = acc && !pwrite && mode_ff != CIL_PWRDN;
  wire unlocked = soft_reset_bit_ff;
  wire wr_ctrl0 = wr && paddr == OFS_CTRL0;
  wire wr_lock = wr && unlocked;
  wire wr_rxflg = wr && paddr == OFS_RXFLG;
  wire wr_txflg = wr && paddr == OFS_TXFLG;
  wire mapped = paddr == OFS_CTRL0 || paddr == OFS_CTRL1 || paddr == OFS_TIM0 || paddr == OFS_TIM1 ||
                paddr == OFS_ACCCTL || paddr == OFS_ACCCODE || paddr == OFS_ACCMASK ||
                paddr == OFS_RXFLG || paddr == OFS_RXIEN || paddr == OFS_TXFLG ||
                paddr == OFS_TXIEN || paddr == OFS_ERRCNT || paddr == OFS_MODE;
  logic [31:0] rd_val;
  assign rd_val = (paddr == OFS_CTRL0) ? {28'h0, wstop_ff, sleep_ack_ff, sleep_request_ff, soft_reset_bit_ff} :
                  (paddr == OFS_CTRL1) ? ctrl1_ff :
                  (paddr == OFS_TIM0) ? tim0_ff :
                  (paddr == OFS_TIM1) ? tim1_ff :
                  (paddr == OFS_ACCCTL) ? accctl_ff :
                  (paddr == OFS_ACCCODE) ? acccode_ff :
                  (paddr == OFS_ACCMASK) ? accmask_ff :
                  (paddr == OFS_RXFLG) ? {24'h0, rxflg_ff} :
                  (paddr == OFS_RXIEN) ? {24'h0, rxien_ff} :
                  (paddr == OFS_TXFLG) ? {29'h0, txe_ff} :
                  (paddr == OFS_TXIEN) ? {29'h0, txien_ff} :
                  (paddr == OFS_ERRCNT) ? {7'h0, tx_err_cnt, 7'h0, rx_err_cnt} :
                  (paddr == OFS_MODE) ? {30'h0, mode_ff} : 32'h0;

  // live conditions; a set condition keeps its flag standing
  logic [7:0] cond;
  assign cond[B_WAKE] = asleep && sleep_ack_ff && rxien_ff[B_WAKE] && bus_act;
  assign cond[B_RWRN] = rx_err_cnt >= WARN_LIMIT;
  assign cond[B_TWRN] = tx_err_cnt >= WARN_LIMIT;
  assign cond[B_RPAS] = rx_err_cnt > PASSIVE_LIMIT;
  assign cond[B_TPAS] = tx_err_cnt > PASSIVE_LIMIT;
  assign cond[B_BOFF] = tx_err_cnt > BOFF_LIMIT;
  assign cond[B_OVR] = overrun_evt;
  assign cond[B_RXF] = rx_done_evt && !asleep;  // no copy into foreground while asleep
  logic [7:0] nxt_rxflg;
  assign nxt_rxflg = cond | (rxflg_ff & ~(wr_rxflg ? pwdata[7:0] : 8'h00));
  logic [2:0] nxt_txe;
  assign nxt_txe = tx_done_evt | (txe_ff & ~(wr_txflg ? pwdata[2:0] : 3'h0));

  // apb answer: one wait state, then pready for a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (ce) begin
      pready_ff <= acc;
      pslverr_ff <= acc && (!mapped || mode_ff == CIL_PWRDN);
      prdata_ff <= rd ? rd_val : 32'h0;
    end
  end

  // control 0: sleep handshake and soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_bit_ff <= 1'b1;
      sleep_request_ff <= 1'b0;
      wstop_ff <= 1'b0;
    end else if (ce && wr_ctrl0) begin
      soft_reset_bit_ff <= pwdata[B_SOFT_RESET_BIT];
      wstop_ff <= pwdata[B_WSTOP];
      // request may only fall once acknowledged
      sleep_request_ff <= pwdata[B_SLEEP_REQUEST] || (sleep_request_ff && !sleep_ack_ff);
    end else if (ce && asleep && bus_act) begin
      sleep_request_ff <= 1'b0;  // bus wakeup withdraws the request
    end
  end

  // sleep ack follows actual entry and exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sleep_ack_ff <= 1'b0;
    else if (ce) begin
      if (!sleep_request_ff || soft_reset_bit_ff || (sleep_ack_ff && bus_act)) sleep_ack_ff <= 1'b0;
      else if (!core_tx_busy && !core_rx_busy && tx_pending == 3'h0) sleep_ack_ff <= 1'b1;
    end
  end

  // locked configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_ff <= CTRL1_RST;
      tim0_ff <= 32'h0;
      tim1_ff <= 32'h0;
      accctl_ff <= 32'h0;
      acccode_ff <= 32'h0;
      accmask_ff <= 32'h0;
    end else if (ce && wr_lock) begin
      if (paddr == OFS_CTRL1) ctrl1_ff <= pwdata;
      if (paddr == OFS_TIM0) tim0_ff <= pwdata;
      if (paddr == OFS_TIM1) tim1_ff <= pwdata;
      if (paddr == OFS_ACCCTL) accctl_ff <= pwdata;
      if (paddr == OFS_ACCCODE) acccode_ff <= pwdata;
      if (paddr == OFS_ACCMASK) accmask_ff <= pwdata;
    end
  end

  // flags and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxflg_ff <= 8'h00;
      rxien_ff <= 8'h00;
      txe_ff <= 3'h7;
      txien_ff <= 3'h0;
      pend_ff <= 3'h0;
    end else if (ce) begin
      rxflg_ff <= nxt_rxflg;
      txe_ff <= nxt_txe;
      pend_ff <= ~nxt_txe;
      if (wr && paddr == OFS_RXIEN) rxien_ff <= pwdata[7:0];
      if (wr && paddr == OFS_TXIEN) txien_ff <= pwdata[2:0];
    end
  end
  assign tx_pending = pend_ff;

  // mode, clocks, halts and deferred actions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= CIL_SOFTRST;
      clk_en_ff <= 1'b0;
      halt_ff <= 1'b1;
      copy_ff <= 1'b0;
      abort_ff <= 1'b0;
      rx_prev_ff <= 1'b1;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      rx_prev_ff <= rx_filt;
      clk_en_ff <= nxt_mode == CIL_NORMAL;
      halt_ff <= nxt_mode == CIL_SOFTRST || nxt_mode == CIL_PWRDN;
      copy_ff <= nxt_mode == CIL_NORMAL;  // pending copy runs once awake
      abort_ff <= nxt_mode == CIL_NORMAL;
    end
  end

  // recessive-run counter for bus join and bus-off recovery
  wire run_done = rec_cnt_ff == 4'(RECESSIVE_RUN - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_ff <= 4'h0;
      boff_runs_ff <= 8'h00;
      joined_ff <= 1'b0;
      boff_rec_ff <= 1'b0;
    end else if (ce) begin
      boff_rec_ff <= 1'b0;
      if (mode_ff != CIL_NORMAL) begin
        joined_ff <= 1'b0;  // rejoin only after fresh idle run
        rec_cnt_ff <= 4'h0;  // boff_runs_ff held, so the count pauses
      end else if (bit_tick) begin
        if (!rx_filt) rec_cnt_ff <= 4'h0;
        else if (run_done) begin
          rec_cnt_ff <= 4'h0;
          joined_ff <= 1'b1;
          if (rxflg_ff[B_BOFF]) begin
            boff_runs_ff <= (boff_runs_ff == 8'(BOFF_RUNS - 1)) ? 8'h00 : boff_runs_ff + 8'h01;
            boff_rec_ff <= boff_runs_ff == 8'(BOFF_RUNS - 1);
          end
        end else rec_cnt_ff <= rec_cnt_ff + 4'h1;
      end
    end
  end

  // tx pin: recessive unless normal and joined
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_pin_ff <= 1'b1;
    else if (ce) tx_pin_ff <= (nxt_mode == CIL_NORMAL && joined_ff) ? core_tx_bit : 1'b1;
  end

  // interrupt lines from flags and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_w_ff <= 1'b0;
      irq_e_ff <= 1'b0;
      irq_r_ff <= 1'b0;
      irq_t_ff <= 1'b0;
    end else if (ce) begin
      irq_w_ff <= nxt_rxflg[B_WAKE] && rxien_ff[B_WAKE];
      irq_e_ff <= |(nxt_rxflg[B_RWRN:B_OVR] & rxien_ff[B_RWRN:B_OVR]);
      irq_r_ff <= nxt_rxflg[B_RXF] && rxien_ff[B_RXF];
      irq_t_ff <= |(nxt_txe & txien_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign bus_tx_pin = tx_pin_ff;
  assign core_clk_en = clk_en_ff;
  assign core_halt = halt_ff;
  assign copy_allow = copy_ff;
  assign abort_allow = abort_ff;
  assign bus_joined = joined_ff;
  assign boff_recovered = boff_rec_ff;
  assign irq_wakeup = irq_w_ff;
  assign irq_error = irq_e_ff;
  assign irq_receive = irq_r_ff;
  assign irq_transmit = irq_t_ff;

  // assertions
  chk_stop_recessive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && host_stop |=> bus_tx_pin) else $error("tx pin not recessive in stop");
  chk_ack_needs_req: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_ack_ff |-> mode_ff == CIL_SLEEP || pwrdn || $past(sleep_request_ff)) else $error("ack without request");
  chk_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sleep_request_ff && !sleep_ack_ff && !(asleep && bus_act) |=> sleep_request_ff) else $error("request cleared early");
  chk_flag_stays: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cond[B_BOFF] |=> rxflg_ff[B_BOFF]) else $error("flag cleared while condition holds");
  chk_lock_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !soft_reset_bit_ff |=> $stable(tim0_ff) && $stable(ctrl1_ff)) else $error("locked register changed");
  chk_wake_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rxflg_ff[B_WAKE]) |-> $past(sleep_ack_ff) && $past(rxien_ff[B_WAKE])) else $error("wakeup not gated");
  chk_irq_err: assert property (@(posedge pclk) disable iff (!presetn)
    ce ##1 1 |-> irq_error == |(rxflg_ff[B_RWRN:B_OVR] & $past(rxien_ff[B_RWRN:B_OVR])))
    else $error("error irq mismatch");
  chk_pwrdn_err: assert property (@(posedge pclk) disable iff (!presetn)
    ce && acc && mode_ff == CIL_PWRDN |=> pready && pslverr) else $error("access in power-down");
  chk_sleep_idle: assert property (@(posedge pclk) disable iff (!presetn)
    ce && $rose(sleep_ack_ff) |-> $past(!core_tx_busy && !core_rx_busy)) else $error("slept while busy");
  chk_pwrdn_tx: assert property (@(posedge pclk) disable iff (!presetn)
    ce && pwrdn |=> bus_tx_pin) else $error("tx pin not recessive in power-down");
  chk_sleep_tx: assert property (@(posedge pclk) disable iff (!presetn)
    asleep |-> bus_tx_pin) else $error("tx pin driven while asleep");
  chk_sleep_nocopy: assert property (@(posedge pclk) disable iff (!presetn)
    ce && asleep |=> !$rose(rxflg_ff[B_RXF])) else $error("receive flag set while asleep");
  chk_softrst_halt: assert property (@(posedge pclk) disable iff (!presetn)
    ce && soft_reset_bit_ff && !sleep_ack_ff |=> core_halt) else $error("core not halted in soft reset");
  chk_clk_normal: assert property (@(posedge pclk) disable iff (!presetn)
    core_clk_en |-> mode_ff == CIL_NORMAL) else $error("core clock running outside normal");
endmodule // cil_ctrl

// File: bench/cil_bus_node.sv
`timescale 1ns/10ps
// far-side bus node: idle recessive line, dominant bursts on command
module cil_bus_node (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command from the bench
  input wire logic [7:0] dom_len,
  input wire logic dom_go,
  // bus side
  output logic bus_rx_pin,
  output logic bit_tick
);
  logic [7:0] dom_cnt_ff;
  logic [1:0] tq_ff;
  // burst length counter and a bit-time divider of four cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dom_cnt_ff <= 8'h00;
      tq_ff <= 2'h0;
    end else begin
      tq_ff <= tq_ff + 2'h1;
      if (dom_go) dom_cnt_ff <= dom_len;
      else if (dom_cnt_ff != 8'h00) dom_cnt_ff <= dom_cnt_ff - 8'h01;
    end
  end
  // line is pulled recessive whenever no node drives it
  assign bus_rx_pin = (dom_cnt_ff == 8'h00);
  assign bit_tick = (tq_ff == 2'h3);
endmodule // cil_bus_node

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import cil_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [7:0] paddr, dom_len;
  logic [31:0] pwdata, prdata, rq;
  logic hstop, hwait, txbusy, rxd, dom_go, rx_pin, tick, tx_pin, clk_en, halt, copy_ok, joined;
  logic abort_ok, ovr;
  logic [8:0] rxc, txc;
  logic [2:0] txd, pend;
  logic i_wk, i_er, i_rx, i_tx;
  int failures = 0;
  int comparisons = 0;

  cil_bus_node cil_bus_node_inst (.pclk(pclk), .presetn(presetn), .dom_len(dom_len), .dom_go(dom_go),
    .bus_rx_pin(rx_pin), .bit_tick(tick));
  cil_ctrl cil_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_stop(hstop), .host_wait(hwait), .core_tx_busy(txbusy), .core_rx_busy(1'b0), .bit_tick(tick),
    .rx_err_cnt(rxc), .tx_err_cnt(txc), .overrun_evt(ovr), .rx_done_evt(rxd), .tx_done_evt(txd),
    .core_tx_bit(1'b0), .bus_rx_pin(rx_pin), .bus_tx_pin(tx_pin), .core_clk_en(clk_en), .core_halt(halt),
    .copy_allow(copy_ok), .abort_allow(abort_ok), .bus_joined(joined), .boff_recovered(), .tx_pending(pend),
    .irq_wakeup(i_wk), .irq_error(i_er), .irq_receive(i_rx), .irq_transmit(i_tx));

  // clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; idle edge first so psel never toggles twice in one time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) failures++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rq, x);
  endtask

  // lets registered flags and irq lines land before they are looked at
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask

  task automatic summarize();
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, hstop, hwait, txbusy, rxd, dom_go, ovr} = '0;
    {paddr, pwdata, dom_len, rxc, txc, txd} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(tx_pin, 1'b1);
    chk(halt, 1'b1);
    rd(OFS_CTRL0, 32'h1);
    rd(OFS_TXFLG, 32'h7);
    rd(OFS_MODE, {30'h0, CIL_SOFTRST});
    chk(clk_en, 1'b0);
    // configuration while locked open, then closed
    wr(OFS_TIM0, 32'h5a);
    wr(OFS_ACCCODE, 32'h1234_5678);
    wr(OFS_CTRL0, 32'h0);
    rd(OFS_MODE, {30'h0, CIL_NORMAL});
    chk(clk_en, 1'b1);
    wr(OFS_TIM0, 32'ha5);
    wr(OFS_ACCCODE, 32'h0);
    rd(OFS_TIM0, 32'h5a);
    rd(OFS_ACCCODE, 32'h1234_5678);
    // counters just below the warning and bus-off limits, and a write to them
    rxc <= 9'h05f;
    txc <= 9'h0ff;
    wr(OFS_ERRCNT, 32'hffff_ffff);
    rd(OFS_ERRCNT, 32'h00ff_005f);
    rd(OFS_RXFLG, 32'h28);
    wr(OFS_RXFLG, 32'h20);
    rxc <= 9'h080;
    txc <= 9'h100;
    settle();
    rd(OFS_RXFLG, 32'h7c);
    chk(i_er, 1'b0);
    wr(OFS_RXIEN, 32'h04);
    settle();
    chk(i_er, 1'b1);
    wr(OFS_RXFLG, 32'h04); // write-one clear of bus-off, refused while the condition still holds
    rd(OFS_RXFLG, 32'h7c);
    txc <= 9'h000;
    wr(OFS_RXFLG, 32'h04);
    rd(OFS_RXFLG, 32'h78);
    settle();
    chk(i_er, 1'b0);
    wr(OFS_RXFLG, 32'h78);
    rd(OFS_RXFLG, 32'h50);
    rxc <= 9'h000;
    wr(OFS_RXFLG, 32'h50);
    rd(OFS_RXFLG, 32'h0);
    // receive and transmit requests
    wr(OFS_RXIEN, 32'h01);
    rxd <= 1'b1;
    @(posedge pclk);
    rxd <= 1'b0;
    settle();
    chk(i_rx, 1'b1);
    wr(OFS_RXFLG, 32'h01);
    settle();
    chk(i_rx, 1'b0);
    ovr <= 1'b1;
    @(posedge pclk);
    ovr <= 1'b0;
    rd(OFS_RXFLG, 32'h02);
    wr(OFS_RXFLG, 32'h02);
    rd(OFS_RXFLG, 32'h0);
    wr(OFS_TXIEN, 32'h7);
    settle();
    chk(i_tx, 1'b1);
    wr(OFS_TXFLG, 32'h7);
    settle();
    chk({i_tx, pend}, 4'h7);
    txd <= 3'b111;
    @(posedge pclk);
    txd <= 3'b000;
    rd(OFS_TXFLG, 32'h7);
    // sleep request while the core is still sending
    txbusy <= 1'b1;
    wr(OFS_RXIEN, 32'h80);
    wr(OFS_CTRL0, 32'h2); // no buffer release just before this
    rd(OFS_CTRL0, 32'h2);
    wr(OFS_CTRL0, 32'h0);
    rd(OFS_CTRL0, 32'h2);
    txbusy <= 1'b0;
    settle();
    rd(OFS_CTRL0, 32'h6);
    rd(OFS_MODE, {30'h0, CIL_SLEEP});
    chk({clk_en, copy_ok, abort_ok, tx_pin, i_wk}, 5'h02);
    // wakeup by a dominant burst on the bus
    dom_len <= 8'd20;
    dom_go <= 1'b1;
    @(posedge pclk);
    dom_go <= 1'b0;
    repeat (30) @(posedge pclk);
    chk({i_wk, joined, abort_ok}, 3'h5);
    rd(OFS_MODE, {30'h0, CIL_NORMAL});
    rd(OFS_CTRL0, 32'h0);
    repeat (60) @(posedge pclk);
    chk(joined, 1'b1);
    wr(OFS_RXFLG, 32'h80);
    settle();
    chk(i_wk, 1'b0);
    // host wait without and with the wait-stop bit, then stop
    hwait <= 1'b1;
    rd(OFS_MODE, {30'h0, CIL_NORMAL});
    wr(OFS_CTRL0, 32'h8);
    settle();
    chk({tx_pin, halt}, 2'h3);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(re, 1'b1);
    hwait <= 1'b0;
    hstop <= 1'b1;
    settle();
    chk({tx_pin, halt}, 2'h3);
    hstop <= 1'b0;
    rd(OFS_MODE, {30'h0, CIL_NORMAL});
    wr(OFS_CTRL0, 32'h1);
    settle();
    chk(halt, 1'b1);
    rd(OFS_MODE, {30'h0, CIL_SOFTRST});
    apb(1'b0, 8'hfc, 32'h0);
    chk(re, 1'b1);
    // wakeup filter: a short glitch keeps the device asleep, a long burst wakes it
    wr(OFS_CTRL1, 32'h1);
    rd(OFS_CTRL1, 32'h1);
    wr(OFS_CTRL0, 32'h2);
    rd(OFS_CTRL0, 32'h6);
    dom_len <= 8'd4;
    dom_go <= 1'b1;
    @(posedge pclk);
    dom_go <= 1'b0;
    repeat (20) @(posedge pclk);
    rd(OFS_CTRL0, 32'h6);
    dom_len <= 8'd20;
    dom_go <= 1'b1;
    @(posedge pclk);
    dom_go <= 1'b0;
    repeat (30) @(posedge pclk);
    rd(OFS_CTRL0, 32'h0);
    // sleep first, then soft reset
    wr(OFS_CTRL0, 32'h2);
    rd(OFS_CTRL0, 32'h6);
    wr(OFS_CTRL0, 32'h3);
    rd(OFS_MODE, {30'h0, CIL_SOFTRST});
    summarize();
  end
endmodule // testbench
